/* rtl/pic_defs.vh */
// constants for the prioritised interrupt controller
// included by the controller and by its bench
`ifndef PIC_DEFS_VH
`define PIC_DEFS_VH
// register indices, byte address is four times the index
`define PIC_IDX_CTRL        4'h0
`define PIC_IDX_STATUS      4'h1
`define PIC_IDX_NORM_PRI    4'h2
`define PIC_IDX_HIGH_VEC    4'h3
// control field positions
`define PIC_CTRL_VSEL_BIT   6
`define PIC_CTRL_CVT_BIT    5
`define PIC_CTRL_RR_BIT     0
// status field positions
`define PIC_STAT_NMI_BIT    7
`define PIC_STAT_HIGH_BIT   1
`define PIC_STAT_NORM_BIT   0
// reset values
`define PIC_CTRL_RST        8'h00
`define PIC_NORM_PRI_RST    8'h00
`define PIC_HIGH_VEC_RST    8'h00
// vector numbers
`define PIC_VEC_RESET       8'h00
`define PIC_VEC_NONE        8'h00
// timing counts in clock cycles
`define PIC_PUSH_CYC        8'h02
`define PIC_JUMP_LONG_CYC   8'h03
`define PIC_JUMP_SHORT_CYC  8'h02
`define PIC_WAKE_CYC        8'h05
`define PIC_RET_SHORT_CYC   8'h04
`define PIC_RET_LONG_CYC    8'h05
// memory size threshold in bytes
`define PIC_SMALL_FLASH     32'h0000_2000
// ahb-lite codes
`define PIC_HTRANS_NONSEQ   2'h2
`define PIC_HTRANS_SEQ      2'h3
`endif

/* rtl/pic_core.v */
// prioritised interrupt controller with ahb-lite register slave
// assumes one 100 MHz clock, synchronous inputs, core acknowledges entry
//
// Notes on behaviour
// - maskable requests pass only while the global enable input is 1
// - a line counts only when its peripheral enable is also set
// - servicing never clears a peripheral flag; flags are only read
// - vector base location follows the vector base select bit
// - select 1: start of boot; 0: after boot; ignored when all boot
// - entry: finish instruction, two push cycles, jump three or two cycles
// - after the jump the vector address is fetched for the taken vector
// - a multi-cycle instruction completes before entry proceeds
// - wake from sleep adds five cycles plus the sleep start-up time
// - return takes four or five cycles depending on program counter width
// - three levels: non-maskable, one high vector, normal
// - high request preempts a normal handler; normal resumes after return
// - non-maskable taken regardless of global enable, never changes it
// - nothing is accepted while a non-maskable handler runs
// - among pending non-maskable requests the lowest vector wins
// - the high vector register raises one vector above all normal ones
// - high vector value zero disables the high level entirely
// - all other vectors are normal; fixed or rotating scheduling
// - vector 0 is reset, 1 non-maskable; both win over normal requests
// - fixed scheduling with base zero picks the lowest pending vector
// - base Y makes Y lowest and Y+1 highest, wrapping around
// - rotating mode writes each acknowledged normal vector into the base
// - rotating enable bit 1 selects rotating, 0 selects fixed
// - after a return one instruction runs before a pending request
`timescale 1ns/10ps
`default_nettype none
`include "pic_defs.vh"

module pic_core #(
  parameter             NUM_VEC     = 32,
  parameter [31:0]      NMI_MASK    = 32'h0000_0002,
  parameter [31:0]      FLASH_BYTES = 32'h0000_2000,
  parameter [31:0]      BOOT_BYTES  = 32'h0000_0000,
  parameter [7:0]       SLEEP_START = 8'h06
) (
  // clock and reset
  input  wire                clock_in,
  input  wire                srst_in,
  // ahb-lite slave
  input  wire                hsel_in,
  input  wire [31:0]         haddr_in,
  input  wire [1:0]          htrans_in,
  input  wire                hwrite_in,
  input  wire [2:0]          hsize_in,
  input  wire                hready_in,
  input  wire [31:0]         hwdata_in,
  output reg                 hreadyout_out,
  output reg                 hresp_out,
  output reg  [31:0]         hrdata_out,
  // peripheral request sources
  input  wire [NUM_VEC-1:0]  irq_flag_in,
  input  wire [NUM_VEC-1:0]  irq_enable_in,
  // core side
  input  wire                global_enable_in,
  input  wire                core_insn_done_in,
  input  wire                core_sleep_in,
  input  wire                core_ack_in,
  input  wire                core_return_from_interrupt_in,
  output reg                 irq_req_out,
  output reg  [7:0]          irq_vector_out,
  output reg                 entry_busy_out,
  output reg                 vector_fetch_out,
  output reg  [31:0]         vector_addr_out,
  output reg                 return_done_out
);

  // one-hot states
  localparam [6:0] S_IDLE   = 7'h01;
  localparam [6:0] S_FINISH = 7'h02;
  localparam [6:0] S_WAKE   = 7'h04;
  localparam [6:0] S_PUSH   = 7'h08;
  localparam [6:0] S_JUMP   = 7'h10;
  localparam [6:0] S_RET    = 7'h20;
  localparam [6:0] S_SKIP   = 7'h40;

  localparam        BIG_FLASH = (FLASH_BYTES > `PIC_SMALL_FLASH);
  localparam [7:0]  JUMP_CYC  = BIG_FLASH ? `PIC_JUMP_LONG_CYC : `PIC_JUMP_SHORT_CYC;
  localparam [7:0]  RET_CYC   = BIG_FLASH ? `PIC_RET_LONG_CYC : `PIC_RET_SHORT_CYC;
  localparam [7:0]  WAKE_CYC  = `PIC_WAKE_CYC + SLEEP_START;
  localparam        ALL_BOOT  = (BOOT_BYTES >= FLASH_BYTES);
  localparam [31:0] VEC_BYTES = BIG_FLASH ? 32'h0000_0004 : 32'h0000_0002;

  // first set bit of mask at or after start, wrapping; vector 0 never taken
  function [8:0] pick_from;
    input [NUM_VEC-1:0] mask;
    input [7:0]         start;
    integer             k;
    integer             idx;
    reg                 found;
    begin
      found     = 1'b0;
      pick_from = 9'h000;
      for (k = 0; k < NUM_VEC; k = k + 1)
      begin
        idx = (start + k) % NUM_VEC;
        if (!found && idx != 0 && mask[idx])
        begin
          found     = 1'b1;
          pick_from = {1'b1, idx[7:0]};
        end
      end
    end
  endfunction

  // registers
  reg [7:0]          ctrl_reg;
  reg [7:0]          norm_pri_reg;
  reg [7:0]          high_vec_reg;
  reg                nmi_ex_reg;
  reg                high_ex_reg;
  reg                norm_ex_reg;
  reg [6:0]          state_reg;
  reg [7:0]          cnt_reg;
  reg [7:0]          taken_vec_reg;
  // ahb data phase
  reg                wr_pend_reg;
  reg [3:0]          wr_idx_reg;
  reg                wr_hit_reg;

  // request qualification
  wire [NUM_VEC-1:0] live       = irq_flag_in & irq_enable_in;
  wire [NUM_VEC-1:0] nmi_live   = live & NMI_MASK[NUM_VEC-1:0];
  wire [NUM_VEC-1:0] mask_live  = global_enable_in ? (live & ~NMI_MASK[NUM_VEC-1:0]) : {NUM_VEC{1'b0}};
  wire               high_on    = (high_vec_reg != `PIC_VEC_NONE) && (high_vec_reg < NUM_VEC);
  wire [NUM_VEC-1:0] high_bit   = high_on ? ({{(NUM_VEC-1){1'b0}}, 1'b1} << high_vec_reg) : {NUM_VEC{1'b0}};
  wire [NUM_VEC-1:0] norm_live  = mask_live & ~high_bit;
  wire               rr_on      = ctrl_reg[`PIC_CTRL_RR_BIT];

  wire [8:0]         nmi_pick   = pick_from(nmi_live, 8'h00);
  wire [8:0]         norm_pick  = pick_from(norm_live, norm_pri_reg + 8'h01);
  wire               high_pend  = |(mask_live & high_bit);

  // winner selection across levels
  reg                win_valid;
  reg [7:0]          win_vec;
  always @*
  begin
    win_valid = 1'b0;
    win_vec   = 8'h00;
    if (nmi_ex_reg)
    begin
      win_valid = 1'b0;
    end
    else if (nmi_pick[8])
    begin
      win_valid = 1'b1;
      win_vec   = nmi_pick[7:0];
    end
    else if (high_pend && !high_ex_reg)
    begin
      win_valid = 1'b1;
      win_vec   = high_vec_reg;
    end
    else if (norm_pick[8] && !high_ex_reg && !norm_ex_reg)
    begin
      win_valid = 1'b1;
      win_vec   = norm_pick[7:0];
    end
  end

  // vector base and address
  wire        vsel      = ctrl_reg[`PIC_CTRL_VSEL_BIT];
  wire [31:0] vec_base  = (vsel || ALL_BOOT) ? 32'h0000_0000 : BOOT_BYTES;
  wire [31:0] vec_addr  = vec_base + {24'h000000, taken_vec_reg} * VEC_BYTES;

  // ahb decode
  wire        ahb_go    = hsel_in && hready_in && (htrans_in == `PIC_HTRANS_NONSEQ || htrans_in == `PIC_HTRANS_SEQ);
  wire [3:0]  a_idx     = haddr_in[5:2];
  wire        a_hit     = (haddr_in[31:6] == 26'h0000000) && (a_idx <= `PIC_IDX_HIGH_VEC);

  reg  [7:0]  rd_val;
  always @*
  begin
    rd_val = 8'h00;
    case (a_idx)
      `PIC_IDX_CTRL:     rd_val = ctrl_reg;
      `PIC_IDX_STATUS:   rd_val = {nmi_ex_reg, 5'h00, high_ex_reg, norm_ex_reg};
      `PIC_IDX_NORM_PRI: rd_val = norm_pri_reg;
      `PIC_IDX_HIGH_VEC: rd_val = high_vec_reg;
      default:           rd_val = 8'h00;
    endcase
  end

  wire        ack_now   = (state_reg == S_IDLE) && irq_req_out && core_ack_in;
  wire        rr_update = ack_now && rr_on && (irq_vector_out != high_vec_reg || !high_on)
                          && !NMI_MASK[irq_vector_out[4:0]];

  // bus slave
  always @(posedge clock_in)
  begin
    if (srst_in)
    begin
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
      hrdata_out    <= 32'h0000_0000;
      wr_pend_reg   <= 1'b0;
      wr_idx_reg    <= 4'h0;
      wr_hit_reg    <= 1'b0;
      ctrl_reg      <= `PIC_CTRL_RST;
      norm_pri_reg  <= `PIC_NORM_PRI_RST;
      high_vec_reg  <= `PIC_HIGH_VEC_RST;
    end
    else
    begin
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
      if (ahb_go)
      begin
        wr_pend_reg <= hwrite_in;
        wr_idx_reg  <= a_idx;
        wr_hit_reg  <= a_hit;
        hrdata_out  <= (a_hit && !hwrite_in) ? {24'h000000, rd_val} : 32'h0000_0000;
      end
      else if (hready_in)
      begin
        wr_pend_reg <= 1'b0;
      end
      if (wr_pend_reg && wr_hit_reg)
      begin
        case (wr_idx_reg)
          `PIC_IDX_CTRL:     ctrl_reg <= hwdata_in[7:0] & 8'h61;
          `PIC_IDX_HIGH_VEC: high_vec_reg <= hwdata_in[7:0];
          default:           ctrl_reg <= ctrl_reg;
        endcase
      end
      if (rr_update)
      begin
        norm_pri_reg <= irq_vector_out;
      end
      else if (wr_pend_reg && wr_hit_reg && wr_idx_reg == `PIC_IDX_NORM_PRI)
      begin
        norm_pri_reg <= hwdata_in[7:0];
      end
    end
  end

  // entry and return sequencer
  always @(posedge clock_in)
  begin
    if (srst_in)
    begin
      state_reg        <= S_IDLE;
      cnt_reg          <= 8'h00;
      taken_vec_reg    <= 8'h00;
      nmi_ex_reg       <= 1'b0;
      high_ex_reg      <= 1'b0;
      norm_ex_reg      <= 1'b0;
      irq_req_out      <= 1'b0;
      irq_vector_out   <= 8'h00;
      entry_busy_out   <= 1'b0;
      vector_fetch_out <= 1'b0;
      vector_addr_out  <= 32'h0000_0000;
      return_done_out  <= 1'b0;
    end
    else
    begin
      vector_fetch_out <= 1'b0;
      return_done_out  <= 1'b0;
      case (state_reg)
        S_IDLE:
        begin
          if (ack_now)
          begin
            irq_req_out    <= 1'b0;
            entry_busy_out <= 1'b1;
            taken_vec_reg  <= irq_vector_out;
            if (NMI_MASK[irq_vector_out[4:0]])
              nmi_ex_reg <= 1'b1;
            else if (high_on && irq_vector_out == high_vec_reg)
              high_ex_reg <= 1'b1;
            else
              norm_ex_reg <= 1'b1;
            if (core_sleep_in)
            begin
              state_reg <= S_WAKE;
              cnt_reg   <= WAKE_CYC;
            end
            else
            begin
              state_reg <= S_FINISH;
            end
          end
          else if (core_return_from_interrupt_in)
          begin
            irq_req_out <= 1'b0;
            state_reg   <= S_RET;
            cnt_reg     <= RET_CYC;
            if (nmi_ex_reg)
              nmi_ex_reg <= 1'b0;
            else if (high_ex_reg)
              high_ex_reg <= 1'b0;
            else
              norm_ex_reg <= 1'b0;
          end
          else
          begin
            irq_req_out    <= win_valid;
            irq_vector_out <= win_valid ? win_vec : 8'h00;
          end
        end
        S_FINISH:
        begin
          if (core_insn_done_in)
          begin
            state_reg <= S_PUSH;
            cnt_reg   <= `PIC_PUSH_CYC;
          end
        end
        S_WAKE:
        begin
          if (cnt_reg <= 8'h01)
          begin
            state_reg <= S_FINISH;
          end
          cnt_reg <= cnt_reg - 8'h01;
        end
        S_PUSH:
        begin
          if (cnt_reg <= 8'h01)
          begin
            state_reg <= S_JUMP;
            cnt_reg   <= JUMP_CYC;
          end
          else
          begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        S_JUMP:
        begin
          if (cnt_reg <= 8'h01)
          begin
            state_reg        <= S_IDLE;
            entry_busy_out   <= 1'b0;
            vector_fetch_out <= 1'b1;
            vector_addr_out  <= vec_addr;
          end
          else
          begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        S_RET:
        begin
          if (cnt_reg <= 8'h01)
          begin
            state_reg       <= S_SKIP;
            return_done_out <= 1'b1;
          end
          else
          begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        S_SKIP:
        begin
          if (core_insn_done_in)
          begin
            state_reg <= S_IDLE;
          end
        end
        default:
        begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

/* test/pic_core_properties.sv */
// port assertions for the interrupt controller
// bound into every pic_core; one clock domain
`timescale 1ns/10ps
`default_nettype none
module pic_chk #(
  parameter NUM_VEC = 32
) (
  // clock and reset
  input wire logic               clock_in,
  input wire logic               srst_in,
  // sources
  input wire logic [NUM_VEC-1:0] irq_flag_in,
  input wire logic [NUM_VEC-1:0] irq_enable_in,
  // core side
  input wire logic               global_enable_in,
  input wire logic               core_insn_done_in,
  input wire logic               core_sleep_in,
  input wire logic               core_ack_in,
  input wire logic               core_return_from_interrupt_in,
  input wire logic               irq_req_out,
  input wire logic [7:0]         irq_vector_out,
  input wire logic               entry_busy_out,
  input wire logic               vector_fetch_out,
  input wire logic               return_done_out
);
  logic [NUM_VEC-1:0] live_reg;
  logic [NUM_VEC-1:0] live2_reg;
  logic               ge_reg;
  logic               ge2_reg;
  logic               nmi_run_reg;
  default clocking @(posedge clock_in); endclocking
  default disable iff (srst_in);
  // input history, non-maskable level
  always_ff @(posedge clock_in)
  begin
    live_reg <= irq_flag_in & irq_enable_in;
    live2_reg <= live_reg;
    ge_reg <= global_enable_in;
    ge2_reg <= ge_reg;
    if (srst_in || return_done_out)
      nmi_run_reg <= 1'b0;
    else if (core_ack_in && irq_req_out && irq_vector_out == 8'h01)
      nmi_run_reg <= 1'b1;
  end
  mask_gate_a: assert property (irq_req_out && !ge_reg && !ge2_reg |-> irq_vector_out == 8'h01)
    else $error("masked request passed");
  line_gate_a: assert property (irq_req_out |-> live_reg[irq_vector_out[4:0]] || live2_reg[irq_vector_out[4:0]])
    else $error("disabled line requested");
  entry_time_a: assert property (core_ack_in && irq_req_out && !core_sleep_in ##1 core_insn_done_in
    |=> entry_busy_out [*4] ##1 vector_fetch_out && !entry_busy_out) else $error("entry timing");
  multi_wait_a: assert property (core_ack_in && irq_req_out ##1 !core_insn_done_in
    |=> !vector_fetch_out [*5]) else $error("fetch before insn done");
  sleep_time_a: assert property (core_ack_in && irq_req_out && core_sleep_in
    |-> !vector_fetch_out [*8] ##1 !vector_fetch_out [*8] ##[1:2] vector_fetch_out) else $error("wake timing");
  ret_time_a: assert property (core_return_from_interrupt_in |=> !return_done_out [*3] ##[1:2] return_done_out)
    else $error("return timing");
  nmi_block_a: assert property (irq_req_out |-> !nmi_run_reg)
    else $error("request during nmi");
  ret_skip_a: assert property (return_done_out |=> !irq_req_out)
    else $error("request right after return");
  ack_take_a: assert property (core_ack_in && irq_req_out && !entry_busy_out |=> !irq_req_out && entry_busy_out)
    else $error("ack not taken");
endmodule
bind pic_core pic_chk #(.NUM_VEC(NUM_VEC)) chk (
  .clock_in, .srst_in, .irq_flag_in, .irq_enable_in, .global_enable_in, .core_insn_done_in,
  .core_sleep_in, .core_ack_in, .core_return_from_interrupt_in, .irq_req_out, .irq_vector_out, .entry_busy_out,
  .vector_fetch_out, .return_done_out
);
`default_nettype wire

/* test/pic_core_model.sv */
// behavioural core: acks, instruction ends, sleep, return
// driven on rising edges of the block clock
`timescale 1ns/10ps
`default_nettype none
module pic_core_model (
  // clock and reset
  input  wire logic clock_in,
  input  wire logic srst_in,
  // bench controls
  input  wire logic auto_ack_in,
  input  wire logic slow_in,
  input  wire logic sleep_in,
  input  wire logic ret_req_in,
  // controller side
  input  wire logic irq_req_in,
  input  wire logic entry_busy_in,
  output var  logic core_ack_out,
  output var  logic core_insn_done_out,
  output var  logic core_sleep_out,
  output var  logic core_return_from_interrupt_out
);
  logic [1:0] cnt_reg;
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      cnt_reg <= 2'h0;
      core_ack_out <= 1'b0;
      core_insn_done_out <= 1'b0;
      core_sleep_out <= 1'b0;
      core_return_from_interrupt_out <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_reg + 2'h1;
      core_ack_out <= auto_ack_in && irq_req_in && !core_ack_out;
      core_insn_done_out <= !slow_in || cnt_reg == 2'h3;
      core_sleep_out <= sleep_in;
      core_return_from_interrupt_out <= ret_req_in && !entry_busy_in;
    end
  end
endmodule
`default_nettype wire

/* test/tb_top.sv */
// self-checking bench for the interrupt controller
// bench drives bus and sources; core model answers
`timescale 1ns/10ps
`default_nettype none
`include "pic_defs.vh"
`define CHK(n, e, v) begin compares++; if ((v) !== (e)) begin error_cnt++; \
  $display("Error %s exp %0h got %0h", n, e, v); end end
module tb_top;
  logic        clk = 1'b0;
  logic        srst, hsel, hwrite, ge, auto_ack, slow, sleep, ret_req;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, flag, en, rdv;
  wire  logic  hrdy, hresp, req, busy, fetch, done, ack, idone, slp, return_from_interrupt;
  wire  logic [7:0]  vec;
  wire  logic [31:0] hrdata, vaddr;
  int          error_cnt, compares;
  always #5 clk = ~clk;
  pic_core #(.BOOT_BYTES(32'h0000_0400)) uut (
    .clock_in(clk), .srst_in(srst), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(3'h2), .hready_in(hrdy), .hwdata_in(hwdata), .hreadyout_out(hrdy),
    .hresp_out(hresp), .hrdata_out(hrdata), .irq_flag_in(flag), .irq_enable_in(en),
    .global_enable_in(ge), .core_insn_done_in(idone), .core_sleep_in(slp), .core_ack_in(ack),
    .core_return_from_interrupt_in(return_from_interrupt), .irq_req_out(req), .irq_vector_out(vec), .entry_busy_out(busy),
    .vector_fetch_out(fetch), .vector_addr_out(vaddr), .return_done_out(done));
  pic_core_model core (
    .clock_in(clk), .srst_in(srst), .auto_ack_in(auto_ack), .slow_in(slow), .sleep_in(sleep),
    .ret_req_in(ret_req), .irq_req_in(req), .entry_busy_in(busy), .core_ack_out(ack),
    .core_insn_done_out(idone), .core_sleep_out(slp), .core_return_from_interrupt_out(return_from_interrupt));
  task automatic ck(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bus(input logic w, input logic [3:0] i, input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= `PIC_HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {26'h0, i, 2'h0};
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge clk); while (hrdy !== 1'b1);
    rdv = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask
  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    bus(1'b1, i, d);
  endtask
  task automatic rdc(input logic [3:0] i, input logic [7:0] e);
    bus(1'b0, i, 8'h00);
    `CHK("reg", {24'h0, e}, rdv)
  endtask
  task automatic rq(input logic r, input logic [7:0] v);
    ck(4);
    `CHK("req", r, req)
    if (r) `CHK("vec", v, vec)
  endtask
  task automatic take(input logic [31:0] a);
    int n = 0;
    auto_ack <= 1'b1;
    do @(posedge clk) n++; while (fetch !== 1'b1 && n < 60);
    auto_ack <= 1'b0;
    `CHK("fetch", 1'b1, fetch)
    `CHK("vaddr", a, vaddr)
  endtask
  task automatic ret();
    int n = 0;
    ret_req <= 1'b1;
    @(posedge clk);
    ret_req <= 1'b0;
    do @(posedge clk) n++; while (done !== 1'b1 && n < 20);
    `CHK("ret_done", 1'b1, done)
    ck(2);
  endtask
  task automatic t_regs();
    rdc(`PIC_IDX_STATUS, 8'h00);
    wr(`PIC_IDX_CTRL, 8'hFF);
    rdc(`PIC_IDX_CTRL, 8'h61);
    wr(`PIC_IDX_STATUS, 8'hFF);
    rdc(`PIC_IDX_STATUS, 8'h00);
    rdc(4'h9, 8'h00);
    wr(`PIC_IDX_CTRL, 8'h00);
    $display("regs test done");
  endtask
  task automatic t_mask();
    flag <= 32'h0000_0020;
    en <= 32'h0000_0020;
    rq(1'b0, 8'h00);
    ge <= 1'b1;
    rq(1'b1, 8'h05);
    en <= 32'h0000_0000;
    rq(1'b0, 8'h00);
    en <= 32'h0000_0022;
    flag <= 32'h0000_0022;
    ge <= 1'b0;
    rq(1'b1, 8'h01);
    ge <= 1'b1;
    rq(1'b1, 8'h01);
    flag <= 32'h0000_0020;
    $display("mask test done");
  endtask
  task automatic t_entry();
    take(32'h0000_040A);
    ret();
    rq(1'b1, 8'h05);
    wr(`PIC_IDX_CTRL, 8'h40);
    take(32'h0000_000A);
    ret();
    wr(`PIC_IDX_CTRL, 8'h00);
    slow <= 1'b1;
    take(32'h0000_040A);
    slow <= 1'b0;
    ret();
    sleep <= 1'b1;
    take(32'h0000_040A);
    sleep <= 1'b0;
    ret();
    $display("entry test done");
  endtask
  task automatic t_order();
    flag <= 32'h0000_0220;
    en <= 32'h0000_0220;
    rq(1'b1, 8'h05);
    wr(`PIC_IDX_NORM_PRI, 8'h05);
    rq(1'b1, 8'h09);
    wr(`PIC_IDX_NORM_PRI, 8'h09);
    rq(1'b1, 8'h05);
    wr(`PIC_IDX_NORM_PRI, 8'h00);
    wr(`PIC_IDX_CTRL, 8'h01);
    take(32'h0000_040A);
    rdc(`PIC_IDX_NORM_PRI, 8'h05);
    ret();
    rq(1'b1, 8'h09);
    wr(`PIC_IDX_CTRL, 8'h00);
    take(32'h0000_0412);
    rdc(`PIC_IDX_NORM_PRI, 8'h05);
    ret();
    wr(`PIC_IDX_NORM_PRI, 8'h00);
    $display("order test done");
  endtask
  task automatic t_high();
    take(32'h0000_040A);
    rq(1'b0, 8'h00);
    wr(`PIC_IDX_HIGH_VEC, 8'h09);
    rq(1'b1, 8'h09);
    take(32'h0000_0412);
    flag <= 32'h0000_0020;
    ret();
    rq(1'b0, 8'h00);
    ret();
    rq(1'b1, 8'h05);
    $display("high test done");
  endtask
  task automatic t_nmi();
    flag <= 32'h0000_0222;
    en <= 32'h0000_0222;
    ge <= 1'b0;
    rq(1'b1, 8'h01);
    ge <= 1'b1;
    take(32'h0000_0402);
    rq(1'b0, 8'h00);
    flag <= 32'h0000_0220;
    ret();
    rq(1'b1, 8'h09);
    $display("nmi test done");
  endtask
  task automatic wrap_up();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    {hsel, hwrite, ge, auto_ack, slow, sleep, ret_req, htrans} = '0;
    {haddr, hwdata, flag, en, rdv} = '0;
    srst = 1'b1;
    error_cnt = 0;
    compares = 0;
    ck(8);
    srst <= 1'b0;
    ck(1);
    t_regs();
    t_mask();
    t_entry();
    t_order();
    t_high();
    t_nmi();
    wrap_up();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    wrap_up();
  end
endmodule
`default_nettype wire
